// >>> include/evs_defs.svh
`ifndef EVS_DEFS_SVH
`define EVS_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define EVS_IDX_STACK_PTR    16'hff00
`define EVS_IDX_STATUS       16'hff01
`define EVS_IDX_BLOCK_PROT   16'hffcf
`define EVS_IDX_MASK_OPTION  16'hffd0
`define EVS_IDX_WDOG_CLEAR   16'hffff

// ----------------------------------------------------------------------
// Vector table
// ----------------------------------------------------------------------
`define EVS_VEC_FIRST        16'hffdc
`define EVS_VEC_BYTES        36
`define EVS_VEC_ADC          16'hffde
`define EVS_VEC_KBD          16'hffe0
`define EVS_VEC_SER_TX       16'hffe2
`define EVS_VEC_SER_RX       16'hffe4
`define EVS_VEC_SER_ERR      16'hffe6
`define EVS_VEC_T2_OVF       16'hffec
`define EVS_VEC_T2_CH1       16'hffee
`define EVS_VEC_T2_CH0       16'hfff0
`define EVS_VEC_T1_OVF       16'hfff2
`define EVS_VEC_T1_CH1       16'hfff4
`define EVS_VEC_T1_CH0       16'hfff6
`define EVS_VEC_EXT_REQ      16'hfffa
`define EVS_VEC_SOFT         16'hfffc
`define EVS_FLAGS_USED       16'hf9fa

// ----------------------------------------------------------------------
// Stack and non-volatile defaults
// ----------------------------------------------------------------------
`define EVS_SP_RESET         16'h00ff
`define EVS_ENTRY_BYTES      3'h5
`define EVS_CALL_BYTES       3'h2
`define EVS_NV_BLANK         8'hff
`define EVS_RESP_OKAY        2'h0
`define EVS_RESP_SLVERR      2'h2

`endif

// >>> include/evs_pkg.sv
package evs_pkg;

   typedef enum logic [1:0] {
      EVS_IDLE   = 2'b00,
      EVS_PUSH   = 2'b01,
      EVS_VEC_HI = 2'b11,
      EVS_VEC_LO = 2'b10
   } evs_state_type;

endpackage

// >>> hdl/evs_exception_unit.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "evs_defs.svh"
module evs_exception_unit #(
   parameter int ADDR_W = 18
) (
   input  wire logic        MCLK_I,
   input  wire logic        RESET_N_I,
   input  wire logic [17:0] AWADDR_I,
   input  wire logic        AWVALID_I,
   output logic             AWREADY_O,
   input  wire logic [31:0] WDATA_I,
   input  wire logic [3:0]  WSTRB_I,
   input  wire logic        WVALID_I,
   output logic             WREADY_O,
   output logic [1:0]       BRESP_O,
   output logic             BVALID_O,
   input  wire logic        BREADY_I,
   input  wire logic [17:0] ARADDR_I,
   input  wire logic        ARVALID_I,
   output logic             ARREADY_O,
   output logic [31:0]      RDATA_O,
   output logic [1:0]       RRESP_O,
   output logic             RVALID_O,
   input  wire logic        RREADY_I,
   input  wire logic [15:0] PENDING_FLAG_I,
   input  wire logic        ENTRY_REQ_I,
   input  wire logic        SOFTWARE_INTERRUPT_INSTRUCTION_I,
   input  wire logic        CALL_I,
   input  wire logic [15:0] RETURN_ADDR_I,
   input  wire logic        PULL_I,
   input  wire logic [15:0] CPU_PC_I,
   input  wire logic [7:0]  CPU_X_I,
   input  wire logic [7:0]  CPU_A_I,
   input  wire logic [7:0]  CPU_CCR_I,
   input  wire logic        NVM_WE_I,
   input  wire logic [15:0] NVM_ADDR_I,
   input  wire logic [7:0]  NVM_DATA_I,
   output logic             IRQ_PENDING_O,
   output logic             BUSY_O,
   output logic             STACK_WE_O,
   output logic [15:0]      STACK_ADDR_O,
   output logic [7:0]       STACK_DATA_O,
   output logic [15:0]      VECTOR_O,
   output logic             ENTRY_DONE_O,
   output logic [15:0]      STACK_PTR_O,
   output logic             WATCHDOG_COUNTER_CLR_O,
   output logic [7:0]       OSCILLATOR_SELECT_O,
   output logic [7:0]       BLOCK_PROTECT_O
);

   // -------------------------------------------------------------------
   // Elaboration check
   // -------------------------------------------------------------------
   if (ADDR_W != 18) begin : g_bad_addr
      $error("ADDR_W must be 18 to reach every register index.");
   end

   // -------------------------------------------------------------------
   // Non-volatile storage
   // -------------------------------------------------------------------
   // These bytes carry no reset: they model flash cells, so they keep
   // their value through RESET_N_I and start out blank.
   logic [7:0] vec_mem [0:`EVS_VEC_BYTES-1] = '{default: `EVS_NV_BLANK};
   logic [7:0] block_protect_byte = `EVS_NV_BLANK;
   logic [7:0] mask_option_byte   = `EVS_NV_BLANK;

   always_ff @(posedge MCLK_I) begin
      if (NVM_WE_I) begin
         if (NVM_ADDR_I == `EVS_IDX_BLOCK_PROT) begin
            block_protect_byte <= NVM_DATA_I;
         end
         if (NVM_ADDR_I == `EVS_IDX_MASK_OPTION) begin
            mask_option_byte <= NVM_DATA_I;
         end
         if (NVM_ADDR_I >= `EVS_VEC_FIRST) begin
            vec_mem[vec_index(NVM_ADDR_I)] <= NVM_DATA_I;
         end
      end
   end

   assign OSCILLATOR_SELECT_O = mask_option_byte;
   assign BLOCK_PROTECT_O     = block_protect_byte;

   function automatic logic [5:0] vec_index(input logic [15:0] addr);
      logic [15:0] diff;
      diff = addr - `EVS_VEC_FIRST;
      return diff[5:0];
   endfunction

   // -------------------------------------------------------------------
   // Source priority and vector map
   // -------------------------------------------------------------------
   // Source code 0 stands for the software interrupt instruction.
   function automatic logic [15:0] vec_base(input logic [3:0] src);
      logic [15:0] base;
      base = `EVS_VEC_SOFT;
      unique case (src)
         4'hf:    base = `EVS_VEC_ADC;
         4'he:    base = `EVS_VEC_KBD;
         4'hd:    base = `EVS_VEC_SER_TX;
         4'hc:    base = `EVS_VEC_SER_RX;
         4'hb:    base = `EVS_VEC_SER_ERR;
         4'h8:    base = `EVS_VEC_T2_OVF;
         4'h7:    base = `EVS_VEC_T2_CH1;
         4'h6:    base = `EVS_VEC_T2_CH0;
         4'h5:    base = `EVS_VEC_T1_OVF;
         4'h4:    base = `EVS_VEC_T1_CH1;
         4'h3:    base = `EVS_VEC_T1_CH0;
         4'h1:    base = `EVS_VEC_EXT_REQ;
         default: base = `EVS_VEC_SOFT;
      endcase
      return base;
   endfunction

   logic [15:0] pend_used;
   logic [3:0]  sel_src;
   logic        any_pend;

   assign pend_used = PENDING_FLAG_I & `EVS_FLAGS_USED;
   assign any_pend  = |pend_used;

   // The loop runs from the lowest rank upward so that the smallest
   // flag number, which ranks highest, is the one left standing.
   always_comb begin
      sel_src = 4'h0;
      for (int i = 15; i >= 1; i--) begin
         if (pend_used[i]) begin
            sel_src = 4'(i);
         end
      end
   end

   // -------------------------------------------------------------------
   // Entry and call sequencer
   // -------------------------------------------------------------------
   evs_pkg::evs_state_type state_q;
   logic [39:0] frame_q;
   logic [2:0]  count_q;
   logic        entry_q;
   logic [15:0] base_q;
   logic [15:0] sp_q;
   logic [7:0]  vec_hi_q;
   logic        sp_wr;
   logic [15:0] sp_wr_val;

   assign BUSY_O      = (state_q != evs_pkg::EVS_IDLE);
   assign STACK_PTR_O = sp_q;

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         state_q <= evs_pkg::EVS_IDLE;
         frame_q <= 40'h0;
         count_q <= 3'h0;
         entry_q <= 1'b0;
         base_q  <= 16'h0;
      end else begin
         unique case (state_q)
            evs_pkg::EVS_IDLE: begin
               if (SOFTWARE_INTERRUPT_INSTRUCTION_I ||
                   (ENTRY_REQ_I && any_pend)) begin
                  // Upper index byte is left off the frame.
                  frame_q <= {CPU_PC_I[7:0], CPU_PC_I[15:8], CPU_X_I,
                              CPU_A_I, CPU_CCR_I};
                  count_q <= `EVS_ENTRY_BYTES;
                  entry_q <= 1'b1;
                  base_q  <= SOFTWARE_INTERRUPT_INSTRUCTION_I ?
                             `EVS_VEC_SOFT : vec_base(sel_src);
                  state_q <= evs_pkg::EVS_PUSH;
               end else if (CALL_I) begin
                  frame_q <= {RETURN_ADDR_I[7:0], RETURN_ADDR_I[15:8],
                              24'h0};
                  count_q <= `EVS_CALL_BYTES;
                  entry_q <= 1'b0;
                  state_q <= evs_pkg::EVS_PUSH;
               end
            end
            evs_pkg::EVS_PUSH: begin
               frame_q <= {frame_q[31:0], 8'h0};
               count_q <= count_q - 3'h1;
               if (count_q == 3'h1) begin
                  state_q <= entry_q ? evs_pkg::EVS_VEC_HI
                                     : evs_pkg::EVS_IDLE;
               end
            end
            evs_pkg::EVS_VEC_HI: begin
               state_q <= evs_pkg::EVS_VEC_LO;
            end
            evs_pkg::EVS_VEC_LO: begin
               state_q <= evs_pkg::EVS_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Vector fetch
   // -------------------------------------------------------------------
   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         vec_hi_q     <= 8'h0;
         VECTOR_O     <= 16'h0;
         ENTRY_DONE_O <= 1'b0;
      end else begin
         ENTRY_DONE_O <= 1'b0;
         if (state_q == evs_pkg::EVS_VEC_HI) begin
            vec_hi_q <= vec_mem[vec_index(base_q)];
         end
         if (state_q == evs_pkg::EVS_VEC_LO) begin
            VECTOR_O     <= {vec_hi_q,
                             vec_mem[vec_index(base_q + 16'h1)]};
            ENTRY_DONE_O <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Stack pointer and stack writes
   // -------------------------------------------------------------------
   // A push or pull in the same cycle as a software write wins, so the
   // stack never loses track of bytes already moved.
   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         sp_q         <= `EVS_SP_RESET;
         STACK_WE_O   <= 1'b0;
         STACK_ADDR_O <= 16'h0;
         STACK_DATA_O <= 8'h0;
      end else begin
         STACK_WE_O <= 1'b0;
         if (state_q == evs_pkg::EVS_PUSH) begin
            STACK_WE_O   <= 1'b1;
            STACK_ADDR_O <= sp_q;
            STACK_DATA_O <= frame_q[39:32];
            sp_q         <= sp_q - 16'h1;
         end else if (state_q == evs_pkg::EVS_IDLE && PULL_I &&
                      !CALL_I && !(ENTRY_REQ_I && any_pend) &&
                      !SOFTWARE_INTERRUPT_INSTRUCTION_I) begin
            sp_q <= sp_q + 16'h1;
         end else if (sp_wr) begin
            // No range check: placement inside RAM is up to software.
            sp_q <= sp_wr_val;
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         IRQ_PENDING_O <= 1'b0;
      end else begin
         IRQ_PENDING_O <= any_pend;
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite write channel
   // -------------------------------------------------------------------
   logic        aw_held_q;
   logic        w_held_q;
   logic [15:0] aw_idx_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        do_write;
   logic        wr_mapped;

   assign AWREADY_O = !aw_held_q && !BVALID_O;
   assign WREADY_O  = !w_held_q && !BVALID_O;
   assign do_write  = aw_held_q && w_held_q && !BVALID_O;
   assign wr_mapped = (aw_idx_q == `EVS_IDX_STACK_PTR) ||
                      (aw_idx_q == `EVS_IDX_STATUS) ||
                      (aw_idx_q == `EVS_IDX_BLOCK_PROT) ||
                      (aw_idx_q == `EVS_IDX_MASK_OPTION) ||
                      (aw_idx_q >= `EVS_VEC_FIRST);
   assign sp_wr     = do_write && (aw_idx_q == `EVS_IDX_STACK_PTR);
   assign sp_wr_val = {wstrb_q[1] ? wdata_q[15:8] : sp_q[15:8],
                       wstrb_q[0] ? wdata_q[7:0]  : sp_q[7:0]};

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         aw_idx_q  <= 16'h0;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
         BVALID_O  <= 1'b0;
         BRESP_O   <= `EVS_RESP_OKAY;
         WATCHDOG_COUNTER_CLR_O <= 1'b0;
      end else begin
         WATCHDOG_COUNTER_CLR_O <= 1'b0;
         if (AWVALID_I && AWREADY_O) begin
            aw_held_q <= 1'b1;
            aw_idx_q  <= AWADDR_I[17:2];
         end
         if (WVALID_I && WREADY_O) begin
            w_held_q <= 1'b1;
            wdata_q  <= WDATA_I;
            wstrb_q  <= WSTRB_I;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            BVALID_O  <= 1'b1;
            BRESP_O   <= wr_mapped ? `EVS_RESP_OKAY : `EVS_RESP_SLVERR;
            // Any value clears the counter; nothing is stored.
            if (aw_idx_q == `EVS_IDX_WDOG_CLEAR) begin
               WATCHDOG_COUNTER_CLR_O <= 1'b1;
            end
         end else if (BVALID_O && BREADY_I) begin
            BVALID_O <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------------
   logic [15:0] ar_idx;

   assign ARREADY_O = !RVALID_O;
   assign ar_idx    = ARADDR_I[17:2];

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         RVALID_O <= 1'b0;
         RDATA_O  <= 32'h0;
         RRESP_O  <= `EVS_RESP_OKAY;
      end else begin
         if (ARVALID_I && ARREADY_O) begin
            RVALID_O <= 1'b1;
            RRESP_O  <= `EVS_RESP_OKAY;
            RDATA_O  <= 32'h0;
            if (ar_idx == `EVS_IDX_STACK_PTR) begin
               RDATA_O <= {16'h0, sp_q};
            end else if (ar_idx == `EVS_IDX_STATUS) begin
               RDATA_O <= {15'h0, BUSY_O, pend_used};
            end else if (ar_idx == `EVS_IDX_BLOCK_PROT) begin
               RDATA_O <= {24'h0, block_protect_byte};
            end else if (ar_idx == `EVS_IDX_MASK_OPTION) begin
               RDATA_O <= {24'h0, mask_option_byte};
            end else if (ar_idx >= `EVS_VEC_FIRST) begin
               // The watchdog index reads back the reset vector low.
               RDATA_O <= {24'h0, vec_mem[vec_index(ar_idx)]};
            end else begin
               RRESP_O <= `EVS_RESP_SLVERR;
            end
         end else if (RVALID_O && RREADY_I) begin
            RVALID_O <= 1'b0;
         end
      end
   end

endmodule

// >>> verif/evs_checker.sv
`timescale 1ns/100ps
`include "evs_defs.svh"
module evs_checker (
   input wire logic        MCLK_I,
   input wire logic        RESET_N_I,
   input wire logic        AWVALID_I,
   input wire logic        AWREADY_O,
   input wire logic        WVALID_I,
   input wire logic        WREADY_O,
   input wire logic        BVALID_O,
   input wire logic        ARVALID_I,
   input wire logic        ARREADY_O,
   input wire logic        RVALID_O,
   input wire logic [15:0] PENDING_FLAG_I,
   input wire logic        ENTRY_REQ_I,
   input wire logic        SOFTWARE_INTERRUPT_INSTRUCTION_I,
   input wire logic        CALL_I,
   input wire logic        PULL_I,
   input wire logic        NVM_WE_I,
   input wire logic        BUSY_O,
   input wire logic        STACK_WE_O,
   input wire logic [15:0] VECTOR_O,
   input wire logic        ENTRY_DONE_O,
   input wire logic [15:0] STACK_PTR_O,
   input wire logic        WATCHDOG_COUNTER_CLR_O,
   input wire logic [7:0]  OSCILLATOR_SELECT_O,
   input wire logic [7:0]  BLOCK_PROTECT_O
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RESET_N_I);
   logic pull_ok;
   // A pull counts only when no push can win the same cycle.
   assign pull_ok = PULL_I && !BUSY_O && !CALL_I &&
      !SOFTWARE_INTERRUPT_INSTRUCTION_I &&
      !(ENTRY_REQ_I && |(PENDING_FLAG_I & `EVS_FLAGS_USED));
   AST_SP_RESET: assert property (
      $rose(RESET_N_I) |-> STACK_PTR_O == 16'h00ff)
      else $error("Stack pointer left reset at a wrong value.");
   AST_PULL_UP: assert property (
      pull_ok |=> STACK_PTR_O == $past(STACK_PTR_O) + 16'h0001)
      else $error("Pull did not raise the stack pointer by one.");
   AST_ENTRY_SP: assert property (
      ENTRY_DONE_O |-> STACK_PTR_O == $past(STACK_PTR_O, 8) - 16'h0005)
      else $error("Entry did not lower the stack pointer by five.");
   AST_ENTRY_WE: assert property (
      ENTRY_DONE_O |-> !$past(STACK_WE_O, 1) && !$past(STACK_WE_O, 7)
      && $past(STACK_WE_O, 2) && $past(STACK_WE_O, 3) && $past(STACK_WE_O, 4)
      && $past(STACK_WE_O, 5) && $past(STACK_WE_O, 6))
      else $error("Entry did not write exactly five stack bytes.");
   AST_WDOG_PULSE: assert property (
      WATCHDOG_COUNTER_CLR_O |-> $rose(BVALID_O) ##1 !WATCHDOG_COUNTER_CLR_O)
      else $error("Watchdog clear not a single pulse with a response.");
   AST_B_ANSWER: assert property (
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
      else $error("Write response late.");
   AST_R_ANSWER: assert property (
      ARVALID_I && ARREADY_O |=> RVALID_O)
      else $error("Read data late.");
   AST_VEC_HOLD: assert property (
      !ENTRY_DONE_O |-> $stable(VECTOR_O))
      else $error("Vector changed outside an entry.");
   AST_NV_HOLD: assert property (
      !NVM_WE_I |=> $stable(BLOCK_PROTECT_O) && $stable(OSCILLATOR_SELECT_O))
      else $error("Non-volatile byte changed without programming.");
endmodule
bind evs_exception_unit evs_checker i_evs_checker (
   .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .AWVALID_I(AWVALID_I),
   .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
   .BVALID_O(BVALID_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
   .RVALID_O(RVALID_O), .PENDING_FLAG_I(PENDING_FLAG_I),
   .ENTRY_REQ_I(ENTRY_REQ_I), .CALL_I(CALL_I), .PULL_I(PULL_I),
   .SOFTWARE_INTERRUPT_INSTRUCTION_I(SOFTWARE_INTERRUPT_INSTRUCTION_I),
   .NVM_WE_I(NVM_WE_I), .BUSY_O(BUSY_O), .STACK_WE_O(STACK_WE_O),
   .VECTOR_O(VECTOR_O), .ENTRY_DONE_O(ENTRY_DONE_O),
   .STACK_PTR_O(STACK_PTR_O), .WATCHDOG_COUNTER_CLR_O(WATCHDOG_COUNTER_CLR_O),
   .OSCILLATOR_SELECT_O(OSCILLATOR_SELECT_O),
   .BLOCK_PROTECT_O(BLOCK_PROTECT_O));

// >>> verif/evs_stack_ram.sv
`timescale 1ns/100ps
module evs_stack_ram (
   input  wire logic        clk_i,
   input  wire logic        we_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  data_i,
   output logic [31:0]      writes_o,
   output logic [31:0]      stray_o
);
   logic [7:0] mem [0:65535];
   initial begin
      writes_o = 32'h0;
      stray_o  = 32'h0;
   end
   // Stack bytes outside RAM are counted, since they corrupt I/O space.
   always @(posedge clk_i) begin
      if (we_i === 1'b1) begin
         mem[addr_i] <= data_i;
         writes_o    <= writes_o + 32'h1;
         if (addr_i < 16'h0060 || addr_i > 16'h015f) begin
            stray_o <= stray_o + 32'h1;
         end
      end
   end
endmodule

// >>> verif/test_exception_vector_and_stack.sv
`timescale 1ns/100ps
module test_exception_vector_and_stack;
   logic        MCLK_I, RESET_N_I, AWVALID_I, WVALID_I, ARVALID_I;
   logic        ENTRY_REQ_I, SOFT_I, CALL_I, PULL_I, NVM_WE_I;
   logic [17:0] AWADDR_I, ARADDR_I;
   logic [31:0] WDATA_I, RDATA_O, wr_cnt, stray_cnt;
   logic [15:0] PENDING_FLAG_I, RETURN_ADDR_I, CPU_PC_I, NVM_ADDR_I;
   logic [7:0]  CPU_X_I, CPU_A_I, CPU_CCR_I, NVM_DATA_I, nv [0:35], ob, pb;
   logic [1:0]  BRESP_O, RRESP_O, rr;
   logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, BUSY_O;
   logic        IRQ_PENDING_O, STACK_WE_O, ENTRY_DONE_O, WDOG_O;
   logic [15:0] STACK_ADDR_O, VECTOR_O, STACK_PTR_O;
   logic [7:0]  STACK_DATA_O, OSC_O, PROT_O;
   logic [31:0] rd;
   int          bad_count = 0, n_tests = 0, wd_count = 0;
   int          ub [12] = '{1, 3, 4, 5, 6, 7, 8, 11, 12, 13, 14, 15};
   evs_exception_unit i_evs_exception_unit (
      .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .AWADDR_I(AWADDR_I),
      .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I),
      .WSTRB_I(4'hf), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
      .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(1'b1),
      .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
      .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
      .RREADY_I(1'b1), .PENDING_FLAG_I(PENDING_FLAG_I),
      .ENTRY_REQ_I(ENTRY_REQ_I), .SOFTWARE_INTERRUPT_INSTRUCTION_I(SOFT_I),
      .CALL_I(CALL_I), .RETURN_ADDR_I(RETURN_ADDR_I), .PULL_I(PULL_I),
      .CPU_PC_I(CPU_PC_I), .CPU_X_I(CPU_X_I), .CPU_A_I(CPU_A_I),
      .CPU_CCR_I(CPU_CCR_I), .NVM_WE_I(NVM_WE_I), .NVM_ADDR_I(NVM_ADDR_I),
      .NVM_DATA_I(NVM_DATA_I), .IRQ_PENDING_O(IRQ_PENDING_O),
      .BUSY_O(BUSY_O), .STACK_WE_O(STACK_WE_O), .STACK_ADDR_O(STACK_ADDR_O),
      .STACK_DATA_O(STACK_DATA_O), .VECTOR_O(VECTOR_O),
      .ENTRY_DONE_O(ENTRY_DONE_O), .STACK_PTR_O(STACK_PTR_O),
      .WATCHDOG_COUNTER_CLR_O(WDOG_O), .OSCILLATOR_SELECT_O(OSC_O),
      .BLOCK_PROTECT_O(PROT_O));
   evs_stack_ram i_evs_stack_ram (.clk_i(MCLK_I), .we_i(STACK_WE_O),
      .addr_i(STACK_ADDR_O), .data_i(STACK_DATA_O), .writes_o(wr_cnt),
      .stray_o(stray_cnt));
   // ----------------------------------------------------------------
   // Clock, reset values and helpers
   // ----------------------------------------------------------------
   initial begin
      MCLK_I = 1'b0;
      forever #5 MCLK_I = ~MCLK_I;
   end
   initial begin
      {RESET_N_I, AWVALID_I, WVALID_I, ARVALID_I, ENTRY_REQ_I} = '0;
      {SOFT_I, CALL_I, PULL_I, NVM_WE_I, AWADDR_I, ARADDR_I, WDATA_I} = '0;
      {PENDING_FLAG_I, RETURN_ADDR_I, CPU_PC_I, NVM_ADDR_I} = '0;
      {CPU_X_I, CPU_A_I, CPU_CCR_I, NVM_DATA_I} = '0;
   end
   always @(posedge MCLK_I) begin
      if (WDOG_O === 1'b1) begin
         wd_count <= wd_count + 1;
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s: expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up;
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200us;
      bad_count++;
      wrap_up();
   end
   function automatic logic [15:0] vec_base(input logic [15:0] f, logic s);
      logic [15:0] b;
      b = 16'hfffc;
      for (int i = 0; i < 12; i++) begin
         if (!s && f[ub[11 - i]]) begin
            b = 16'hfffc - 16'(2 * ub[11 - i]);
         end
      end
      return b;
   endfunction
   task automatic axi_wr(input logic [15:0] idx, logic [31:0] d);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      AWADDR_I <= {idx, 2'b00};
      WDATA_I <= d;
      AWVALID_I <= 1'b1;
      WVALID_I <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge MCLK_I);
         if (!aw_done && AWREADY_O === 1'b1) begin
            AWVALID_I <= 1'b0;
            aw_done = 1'b1;
         end
         if (!w_done && WREADY_O === 1'b1) begin
            WVALID_I <= 1'b0;
            w_done = 1'b1;
         end
      end
      // The answer is taken only at an edge that sees it standing.
      do begin
         @(posedge MCLK_I);
      end while (BVALID_O !== 1'b1);
      rr = BRESP_O;
   endtask
   task automatic axi_rd(input logic [15:0] idx);
      ARADDR_I <= {idx, 2'b00};
      ARVALID_I <= 1'b1;
      do begin
         @(posedge MCLK_I);
      end while (ARREADY_O !== 1'b1);
      ARVALID_I <= 1'b0;
      do begin
         @(posedge MCLK_I);
      end while (RVALID_O !== 1'b1);
      rd = RDATA_O;
      rr = RRESP_O;
   endtask
   task automatic pulls(input int k);
      repeat (k) begin
         PULL_I <= 1'b1;
         @(posedge MCLK_I);
         PULL_I <= 1'b0;
         @(posedge MCLK_I);
      end
   endtask
   task automatic entry(input logic [15:0] f, logic s);
      logic [15:0] sp0, pc, ev;
      logic [7:0]  x, a, c;
      logic [31:0] w0;
      pc = 16'($urandom);
      {x, a, c} = 24'($urandom);
      sp0 = STACK_PTR_O;
      w0 = wr_cnt;
      ev = vec_base(f, s) - 16'hffdc;
      {PENDING_FLAG_I, ENTRY_REQ_I, SOFT_I} <= {f, 1'b1, s};
      {CPU_PC_I, CPU_X_I, CPU_A_I, CPU_CCR_I} <= {pc, x, a, c};
      @(posedge MCLK_I);
      {PENDING_FLAG_I, ENTRY_REQ_I, SOFT_I} <= '0;
      @(posedge MCLK_I);
      chk("busy", BUSY_O, 32'h1);
      chk("irq", IRQ_PENDING_O, 32'((f & 16'hf9fa) != 16'h0));
      for (int n = 0; n < 20 && ENTRY_DONE_O !== 1'b1; n++) begin
         @(posedge MCLK_I);
      end
      chk("idle", {BUSY_O, IRQ_PENDING_O}, 32'h0);
      chk("vector", VECTOR_O, {nv[ev], nv[ev + 1]});
      chk("entry sp", STACK_PTR_O, sp0 - 16'h5);
      chk("frame", {i_evs_stack_ram.mem[sp0], i_evs_stack_ram.mem[sp0 - 1],
         i_evs_stack_ram.mem[sp0 - 2], i_evs_stack_ram.mem[sp0 - 3]},
         {pc[7:0], pc[15:8], x, a});
      chk("ccr", i_evs_stack_ram.mem[sp0 - 4], c);
      chk("bytes", wr_cnt - w0, 32'h5);
      pulls(5);
      chk("pull sp", STACK_PTR_O, sp0);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [15:0] r16;
      void'($urandom(32'ha3d3));
      repeat (10) @(posedge MCLK_I);
      RESET_N_I <= 1'b1;
      @(posedge MCLK_I);
      chk("sp reset", STACK_PTR_O, 16'h00ff);
      chk("blank", {PROT_O, OSC_O}, 16'hffff);
      for (int i = 0; i < 38; i++) begin
         r16 = 16'($urandom);
         NVM_WE_I <= 1'b1;
         NVM_ADDR_I <= i < 36 ? 16'hffdc + 16'(i) : 16'hffab + 16'(i);
         NVM_DATA_I <= r16[7:0];
         if (i < 36) nv[i] = r16[7:0];
         if (i == 36) pb = r16[7:0];
         if (i == 37) ob = r16[7:0];
         @(posedge MCLK_I);
      end
      NVM_WE_I <= 1'b0;
      @(posedge MCLK_I);
      chk("nv", {PROT_O, OSC_O}, {pb, ob});
      for (int i = 0; i < 36; i++) begin
         axi_rd(16'hffdc + 16'(i));
         chk("vec read", rd, {24'h0, nv[i]});
      end
      axi_wr(16'hffd0, ~{24'h0, ob});
      axi_rd(16'hffd0);
      chk("option", {rr, rd[29:0]}, {2'h0, 22'h0, ob});
      axi_wr(16'hffff, $urandom);
      repeat (2) @(posedge MCLK_I);
      chk("wdog", wd_count, 1);
      axi_rd(16'h1234);
      chk("unmapped", {rr, rd[29:0]}, {2'h2, 30'h0});
      r16 = 16'($urandom);
      PENDING_FLAG_I <= r16;
      axi_rd(16'hff01);
      chk("status", rd, {16'h0, r16 & 16'hf9fa});
      PENDING_FLAG_I <= 16'h0;
      r16 = 16'($urandom);
      axi_wr(16'hff00, {16'h0, r16});
      axi_rd(16'hff00);
      chk("sp rw", {rd[15:0], STACK_PTR_O}, {r16, r16});
      axi_wr(16'hff00, 32'h0150);
      r16 = 16'($urandom);
      RETURN_ADDR_I <= r16;
      CALL_I <= 1'b1;
      @(posedge MCLK_I);
      CALL_I <= 1'b0;
      repeat (6) @(posedge MCLK_I);
      chk("call", {i_evs_stack_ram.mem[16'h0150], i_evs_stack_ram.mem[16'h014f],
         STACK_PTR_O}, {r16[7:0], r16[15:8], 16'h014e});
      pulls(2);
      for (int i = 0; i < 45; i++) begin
         r16 = 16'($urandom) & 16'hf9fa;
         if (i < 12) r16 = 16'h1 << ub[i];
         if (r16 == 0) r16 = 16'h8000;
         entry(r16 | (16'($urandom) & 16'h0605), i == 12 || i == 30);
      end
      chk("wdog end", wd_count, 1);
      chk("stray", stray_cnt, 32'h0);
      wrap_up();
   end
endmodule
